/* pkg/dmsu_pkg.sv */
// Package: register offsets, field positions, reset values and timing counts
package dmsu_pkg;
	// Configuration space offsets (byte addresses within the function's space)
	localparam logic [7:0]  FUNC_SEL_CTRL_OFS   = 8'h51;
	localparam logic [7:0]  HUB_CFG_OFS         = 8'h50;
	// Memory-mapped local memory control registers
	localparam logic [15:0] LM_ROW_KIND_OFS     = 16'h3000;
	localparam logic [15:0] LM_TIMING_OFS       = 16'h3001;
	localparam logic [15:0] LM_CTRL_UPPER_OFS   = 16'h3002;
	// Field positions
	localparam int          MODE_SEL_BIT        = 0;
	localparam int          LOCK_BIT            = 2;
	localparam int          MEM_FREQ_BIT        = 2;
	// Reset values
	localparam logic [7:0]  FUNC_SEL_RST        = 8'h00;
	localparam logic [7:0]  HUB_CFG_RST         = 8'h00;
	localparam logic [7:0]  LM_ROW_KIND_RST     = 8'h00;
	localparam logic [7:0]  LM_TIMING_RST       = 8'hff;
	localparam logic [7:0]  LM_CTRL_UPPER_RST   = 8'h00;
	// Timing
	localparam int          CLK_MHZ             = 25;
	localparam int          RESYNC_NS           = 500;
	localparam int          RESYNC_CYC          = (RESYNC_NS * CLK_MHZ) / 1000;
	localparam int          RESYNC_W            = 5;
	// Function activity encoding
	typedef enum logic [1:0] {
		DMSU_EXT_PORT  = 2'b00,
		DMSU_INT_GFX   = 2'b01,
		DMSU_PCI_ONLY  = 2'b11
	} dmsu_mode_t;
	// Clock resync state: Gray along idle -> switching -> done
	typedef enum logic [1:0] {
		DMSU_CLK_LOW   = 2'b00,
		DMSU_CLK_SYNC  = 2'b01,
		DMSU_CLK_HIGH  = 2'b11
	} dmsu_clk_t;
endpackage

/* src/dmsu_byte_reg.sv */
// Byte register with write strobe and reset value
`timescale 1ns/1ps
module dmsu_byte_reg #(
	parameter logic [7:0] RST_VAL = 8'h00
) (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       ce,
	input  wire logic       wr,
	input  wire logic [7:0] wdata,
	output logic      [7:0] q
);
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q <= RST_VAL;
		end else if (ce && wr) begin
			q <= wdata;
		end
	end
endmodule

/* src/dmsu_mode_select.sv */
// Device mode select, write-once lock, memory clock upshift and local memory registers
`timescale 1ns/1ps
module dmsu_mode_select
	import dmsu_pkg::*;
(
	input  wire logic        SYS_CLK,
	input  wire logic        RST,
	input  wire logic        CE,
	input  wire logic        CFG_WR,
	input  wire logic        CFG_RD,
	input  wire logic [7:0]  CFG_ADDR,
	input  wire logic [7:0]  CFG_WDATA,
	output logic      [7:0]  CFG_RDATA,
	input  wire logic        MM_WR,
	input  wire logic        MM_RD,
	input  wire logic [15:0] MM_ADDR,
	input  wire logic [7:0]  MM_WDATA,
	output logic      [7:0]  MM_RDATA,
	input  wire logic        PCI_ONLY_REQ,
	output logic             HOST_BRIDGE_EN,
	output logic             PORT_BRIDGE_EN,
	output logic             INT_GFX_EN,
	output logic             DISPLAY_TO_HUB,
	output logic             MEM_CLK_133,
	output logic             MEM_CLK_SYNCING
);
	typedef struct packed {
		logic                mode_sel;
		logic                lock;
		logic                freq_sel;
		logic                pci_only;
		dmsu_clk_t           clk_st;
		logic [RESYNC_W-1:0] cnt;
		logic [7:0]          cfg_rdata;
		logic [7:0]          mm_rdata;
		logic                port_en;
		logic                gfx_en;
		logic                hub_fwd;
		logic                clk_133;
		logic                syncing;
		logic                host_en;
	} dmsu_state_t;

	localparam logic [RESYNC_W-1:0] RESYNC_LAST = RESYNC_W'(RESYNC_CYC - 1);

	dmsu_state_t st;
	dmsu_state_t next_st;
	logic        pci_only_s1;
	logic        pci_only_s2;
	logic [7:0]  lm_row_kind;
	logic [7:0]  lm_timing;
	logic [7:0]  lm_ctrl_upper;
	logic        cfg_wr_func;
	logic        cfg_wr_hub;

	assign cfg_wr_func = CFG_WR && (CFG_ADDR == FUNC_SEL_CTRL_OFS);
	assign cfg_wr_hub  = CFG_WR && (CFG_ADDR == HUB_CFG_OFS);

	// Strap-like pin from outside the clock domain
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			pci_only_s1 <= 1'b0;
			pci_only_s2 <= 1'b0;
		end else if (CE) begin
			pci_only_s1 <= PCI_ONLY_REQ;
			pci_only_s2 <= pci_only_s1;
		end
	end

	dmsu_byte_reg #(.RST_VAL(LM_ROW_KIND_RST)) u_row_kind (
		.clk   (SYS_CLK),
		.rst   (RST),
		.ce    (CE),
		.wr    (MM_WR && (MM_ADDR == LM_ROW_KIND_OFS)),
		.wdata (MM_WDATA),
		.q     (lm_row_kind)
	);
	// Slowest timing by default, safe for any card
	dmsu_byte_reg #(.RST_VAL(LM_TIMING_RST)) u_timing (
		.clk   (SYS_CLK),
		.rst   (RST),
		.ce    (CE),
		.wr    (MM_WR && (MM_ADDR == LM_TIMING_OFS)),
		.wdata (MM_WDATA),
		.q     (lm_timing)
	);
	dmsu_byte_reg #(.RST_VAL(LM_CTRL_UPPER_RST)) u_ctrl_upper (
		.clk   (SYS_CLK),
		.rst   (RST),
		.ce    (CE),
		.wr    (MM_WR && (MM_ADDR == LM_CTRL_UPPER_OFS)),
		.wdata (MM_WDATA),
		.q     (lm_ctrl_upper)
	);

	always_comb begin
		next_st = st;
		// Select and lock are taken together until lock is set; afterwards writes fall away
		if (cfg_wr_func && !st.lock) begin
			// Only external -> internal is possible: internal is never left
			next_st.mode_sel = st.mode_sel | CFG_WDATA[MODE_SEL_BIT];
			next_st.lock     = CFG_WDATA[LOCK_BIT];
		end
		next_st.pci_only = pci_only_s2;
		if (cfg_wr_hub) begin
			next_st.freq_sel = CFG_WDATA[MEM_FREQ_BIT];
		end
		// Clock switch: resync finishes within the allowed window
		case (st.clk_st)
			DMSU_CLK_LOW: begin
				next_st.cnt = '0;
				if (st.freq_sel) begin
					next_st.clk_st = DMSU_CLK_SYNC;
				end
			end
			DMSU_CLK_SYNC: begin
				if (st.cnt == RESYNC_LAST) begin
					next_st.clk_st = st.freq_sel ? DMSU_CLK_HIGH : DMSU_CLK_LOW;
					next_st.cnt    = '0;
				end else begin
					next_st.cnt = st.cnt + 1'b1;
				end
			end
			DMSU_CLK_HIGH: begin
				next_st.cnt = '0;
				if (!st.freq_sel) begin
					next_st.clk_st = DMSU_CLK_SYNC;
				end
			end
			default: begin
				next_st.clk_st = DMSU_CLK_LOW;
				next_st.cnt    = '0;
			end
		endcase
		next_st.clk_133 = (next_st.clk_st == DMSU_CLK_HIGH);
		next_st.syncing = (next_st.clk_st == DMSU_CLK_SYNC);
		// Bridge and internal graphics are exclusive; PCI-only kills both
		next_st.gfx_en  = next_st.mode_sel && !next_st.pci_only;
		next_st.port_en = !next_st.mode_sel && !next_st.pci_only;
		next_st.hub_fwd = next_st.pci_only;
		// Function 0 never goes away, but still leaves the block from a flop
		next_st.host_en = 1'b1;
		// Registered read data, one cycle after the strobe
		next_st.cfg_rdata = 8'h00;
		if (CFG_RD) begin
			case (CFG_ADDR)
				FUNC_SEL_CTRL_OFS: begin
					next_st.cfg_rdata[MODE_SEL_BIT] = st.mode_sel;
					next_st.cfg_rdata[LOCK_BIT]     = st.lock;
				end
				HUB_CFG_OFS: begin
					next_st.cfg_rdata[MEM_FREQ_BIT] = st.freq_sel;
				end
				default: begin
					next_st.cfg_rdata = 8'h00;
				end
			endcase
		end
		next_st.mm_rdata = 8'h00;
		if (MM_RD) begin
			case (MM_ADDR)
				LM_ROW_KIND_OFS:   next_st.mm_rdata = lm_row_kind;
				LM_TIMING_OFS:     next_st.mm_rdata = lm_timing;
				LM_CTRL_UPPER_OFS: next_st.mm_rdata = lm_ctrl_upper;
				default:           next_st.mm_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			// External-port mode, 100 MHz memory clock after any reset
			st           <= '0;
			st.mode_sel  <= FUNC_SEL_RST[MODE_SEL_BIT];
			st.lock      <= FUNC_SEL_RST[LOCK_BIT];
			st.freq_sel  <= HUB_CFG_RST[MEM_FREQ_BIT];
			st.clk_st    <= DMSU_CLK_LOW;
			st.port_en   <= 1'b1;
			st.host_en   <= 1'b1;
		end else if (CE) begin
			st <= next_st;
		end
	end

	assign CFG_RDATA       = st.cfg_rdata;
	assign MM_RDATA        = st.mm_rdata;
	assign HOST_BRIDGE_EN  = st.host_en;
	assign PORT_BRIDGE_EN  = st.port_en;
	assign INT_GFX_EN      = st.gfx_en;
	assign DISPLAY_TO_HUB  = st.hub_fwd;
	assign MEM_CLK_133     = st.clk_133;
	assign MEM_CLK_SYNCING = st.syncing;
endmodule

/* test/dmsu_mode_select_properties.sv */
// Port-level checks for the mode select and clock upshift block
`timescale 1ns/1ps
module dmsu_mode_select_properties
	import dmsu_pkg::*;
(
	input wire logic       SYS_CLK,
	input wire logic       RST,
	input wire logic       CE,
	input wire logic       CFG_WR,
	input wire logic [7:0] CFG_ADDR,
	input wire logic [7:0] CFG_WDATA,
	input wire logic       PCI_ONLY_REQ,
	input wire logic       HOST_BRIDGE_EN,
	input wire logic       PORT_BRIDGE_EN,
	input wire logic       INT_GFX_EN,
	input wire logic       DISPLAY_TO_HUB,
	input wire logic       MEM_CLK_133,
	input wire logic       MEM_CLK_SYNCING
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (RST);
	wire sel_wr = CE && CFG_WR && CFG_ADDR == FUNC_SEL_CTRL_OFS && CFG_WDATA[MODE_SEL_BIT];
	sequence s_up;
		CE && CFG_WR && CFG_ADDR == HUB_CFG_OFS && CFG_WDATA[MEM_FREQ_BIT] && !MEM_CLK_133;
	endsequence
	sequence s_hold;
		MEM_CLK_SYNCING[*8] ##1 MEM_CLK_SYNCING[*4];
	endsequence
	property p_excl; !(PORT_BRIDGE_EN && INT_GFX_EN); endproperty
	property p_host; HOST_BRIDGE_EN; endproperty
	property p_rst; $fell(RST) |-> PORT_BRIDGE_EN && !INT_GFX_EN && !MEM_CLK_133; endproperty
	// PCI-only release may bring internal graphics back, so that path is exempt
	property p_rise; $rose(INT_GFX_EN) |-> $past(sel_wr) || $past(DISPLAY_TO_HUB); endproperty
	property p_fall; $fell(INT_GFX_EN) |-> DISPLAY_TO_HUB; endproperty
	property p_pci;
		$rose(PCI_ONLY_REQ) |-> ##[1:4] (DISPLAY_TO_HUB && !INT_GFX_EN && !PORT_BRIDGE_EN);
	endproperty
	property p_up; s_up and !MEM_CLK_SYNCING |=> ##1 MEM_CLK_SYNCING; endproperty
	property p_sync;
		$rose(MEM_CLK_SYNCING) |-> s_hold ##1 (!MEM_CLK_SYNCING && $changed(MEM_CLK_133));
	endproperty
	a_excl: assert property (p_excl) else $error("both graphics functions on");
	a_host: assert property (p_host) else $error("host bridge off");
	a_rst: assert property (p_rst) else $error("bad mode after reset");
	a_rise: assert property (p_rise) else $error("internal graphics without select");
	a_fall: assert property (p_fall) else $error("mode went back to external");
	a_pci: assert property (p_pci) else $error("pci-only mode not entered");
	a_up: assert property (p_up) else $error("upshift did not start");
	a_sync: assert property (p_sync) else $error("resync length wrong");
endmodule

/* test/dmsu_fw_model.sv */
// Firmware model issuing configuration and memory-mapped cycles
`timescale 1ns/1ps
module dmsu_fw_model
	import dmsu_pkg::*;
(
	input  wire logic        SYS_CLK,
	input  wire logic [7:0]  CFG_RDATA,
	input  wire logic [7:0]  MM_RDATA,
	output logic             CFG_WR,
	output logic             CFG_RD,
	output logic      [7:0]  CFG_ADDR,
	output logic      [7:0]  CFG_WDATA,
	output logic             MM_WR,
	output logic             MM_RD,
	output logic      [15:0] MM_ADDR,
	output logic      [7:0]  MM_WDATA
);
	initial {CFG_WR, CFG_RD, MM_WR, MM_RD, CFG_ADDR, CFG_WDATA, MM_ADDR, MM_WDATA} = '0;
	// One access per call; released data is inverted so stale values never match
	task acc(input bit mm, input bit wr, input logic [15:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge SYS_CLK) #1;
		{MM_WR, MM_RD} = mm ? {wr, !wr} : 2'b00;
		{CFG_WR, CFG_RD} = mm ? 2'b00 : {wr, !wr};
		MM_ADDR = a;
		CFG_ADDR = a[7:0];
		{MM_WDATA, CFG_WDATA} = {d, d};
		@(posedge SYS_CLK) #1;
		q = mm ? MM_RDATA : CFG_RDATA;
		{MM_WR, MM_RD, CFG_WR, CFG_RD} = 4'h0;
		{MM_WDATA, CFG_WDATA} = ~{d, d};
	endtask
	task upshift(output logic [7:0] q); // clock generator first, 1 us settle
		repeat (25) @(posedge SYS_CLK);
		acc(0, 1, HUB_CFG_OFS, 8'h04, q);
	endtask
	task probe(input bit abort, output logic [7:0] q); // lock in same write
		acc(0, 1, FUNC_SEL_CTRL_OFS, abort ? 8'h05 : 8'h04, q);
	endtask
endmodule

/* test/dmsu_mode_select_test.sv */
// Self-checking bench for the mode select and clock upshift block
`timescale 1ns/1ps
module dmsu_mode_select_test
	import dmsu_pkg::*;
;
	logic SYS_CLK = 1'b0, RST = 1'b1, CE = 1'b1, PCI_ONLY_REQ = 1'b0;
	logic CFG_WR, CFG_RD, MM_WR, MM_RD, HOST_BRIDGE_EN, PORT_BRIDGE_EN, INT_GFX_EN;
	logic DISPLAY_TO_HUB, MEM_CLK_133, MEM_CLK_SYNCING;
	logic [7:0] CFG_ADDR, CFG_WDATA, CFG_RDATA, MM_WDATA, MM_RDATA, q, d;
	logic [15:0] MM_ADDR;
	int errors = 0, checks_done = 0, m_int;
	dmsu_mode_select i_dmsu_mode_select (.*);
	dmsu_fw_model i_dmsu_fw_model (.*);
	initial forever #20 SYS_CLK = ~SYS_CLK;
	task chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task summarize();
		$display("errors %0d checks %0d", errors, checks_done);
		if (errors == 0 && checks_done > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		#100us;
		errors++;
		summarize();
	end
	initial begin
		void'($urandom(32'h1ceb));
		for (int p = 0; p < 2; p++) begin
			RST = 1'b1;
			repeat (3) @(posedge SYS_CLK);
			#1 RST = 1'b0;
			m_int = 0;
			chk(PORT_BRIDGE_EN, 8'h01);
			chk(MEM_CLK_133, 8'h00);
			chk(HOST_BRIDGE_EN, 8'h01);
			i_dmsu_fw_model.acc(1, 0, LM_TIMING_OFS, 8'h00, q);
			chk(q, 8'hff);
			i_dmsu_fw_model.acc(0, 0, 16'h0077, 8'h00, q);
			chk(q, 8'h00);
			d = 8'($urandom);
			i_dmsu_fw_model.acc(1, 1, LM_CTRL_UPPER_OFS, d, q);
			i_dmsu_fw_model.acc(1, 0, LM_CTRL_UPPER_OFS, 8'h00, q);
			chk(q, d);
			// Mode is settled first: the faster memory clock is only requested in external mode
			i_dmsu_fw_model.probe(p[0], q);
			m_int = p;
			chk({INT_GFX_EN, PORT_BRIDGE_EN}, m_int ? 8'h02 : 8'h01);
			// Random retry after lock must change nothing in either direction
			d = 8'($urandom);
			i_dmsu_fw_model.acc(0, 1, FUNC_SEL_CTRL_OFS, d, q);
			i_dmsu_fw_model.acc(0, 0, FUNC_SEL_CTRL_OFS, 8'h00, q);
			chk(q & 8'h05, 8'h04 | 8'(m_int));
			chk({INT_GFX_EN, PORT_BRIDGE_EN}, m_int ? 8'h02 : 8'h01);
			if (m_int == 0) begin
				i_dmsu_fw_model.upshift(q);
			end
			@(posedge SYS_CLK) #1;
			chk(MEM_CLK_SYNCING, m_int ? 8'h00 : 8'h01);
			repeat (12) @(posedge SYS_CLK);
			#1 chk({MEM_CLK_133, MEM_CLK_SYNCING}, m_int ? 8'h00 : 8'h02);
			// A write while the clock enable is low must not reach the timing register
			CE = 1'b0;
			i_dmsu_fw_model.acc(1, 1, LM_TIMING_OFS, 8'h00, q);
			CE = 1'b1;
			i_dmsu_fw_model.acc(1, 0, LM_TIMING_OFS, 8'h00, q);
			chk(q, 8'hff);
		end
		PCI_ONLY_REQ = 1'b1;
		repeat (4) @(posedge SYS_CLK);
		#1 chk({DISPLAY_TO_HUB, INT_GFX_EN, PORT_BRIDGE_EN}, 8'h04);
		summarize();
	end
endmodule
bind dmsu_mode_select dmsu_mode_select_properties i_dmsu_mode_select_properties (.*);
